//--- hw/ptc_timer.sv
// Purpose: Prescaled 8/16-bit timer/counter with an Avalon-MM register slave
// Assumes: mclk 40 MHz, synchronous active-high sys_rst
// Notes:   Each access is answered one cycle after it is presented
//
// Functional notes
// - Count only while run bit set
// - Bit 6 selects 8-bit or 16-bit width
// - Bit 5 selects instruction tick or pin
// - Bit 4 selects falling or rising pin edge
// - Bit 3 bypasses the prescaler
// - Ratio field gives divide by 2^(code+1)
// - Prescaler is a dedicated 8-bit counter
// - Bypassed timer mode counts every tick
// - Count write holds counting two ticks
// - Pin synchronised before use, with latency
// - Control register read/write, resets all ones
// - Wrap sets overflow flag; enable masks it
// - Low byte read copies high byte in 16-bit mode
// - Low byte write loads high from buffer in 16-bit mode
// - Count write clears prescaler count unless bypassed
`default_nettype none

module ptc_timer #(
    parameter int TICK_DIV = ptc_pkg::MCLK_PER_TICK
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // External count pin
    input wire logic ext_count_pin,
    // Overflow interrupt request
    output logic overflowIrq
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [7:0] timer_control;
        logic [7:0] countLow;
        logic [7:0] countHigh;
        logic [7:0] count_high_buffer;
        logic overflow_flag;
        logic overflow_irq_en;
        logic [$clog2(TICK_DIV)-1:0] tickDiv;
        logic instruction_tick;
        logic pinPrev;
        logic [1:0] holdoff;
        logic waitReq;
        logic [31:0] readData;
        logic irq;
    } ptc_state_s;

    ptc_state_s st_ff;
    ptc_state_s nxt_st;

    // ****************************************************************
    // Control field decode
    // ****************************************************************
    logic count_run;
    logic narrow_width_sel;
    logic count_source_sel;
    logic edge_polarity_sel;
    logic divider_bypass;
    logic [2:0] divider_ratio_sel;

    assign count_run = st_ff.timer_control[ptc_pkg::BIT_RUN];
    assign narrow_width_sel = st_ff.timer_control[ptc_pkg::BIT_NARROW];
    assign count_source_sel = st_ff.timer_control[ptc_pkg::BIT_SOURCE];
    assign edge_polarity_sel = st_ff.timer_control[ptc_pkg::BIT_EDGE];
    assign divider_bypass = st_ff.timer_control[ptc_pkg::BIT_BYPASS];
    assign divider_ratio_sel = st_ff.timer_control[ptc_pkg::RATIO_MSB:ptc_pkg::RATIO_LSB];

    // ****************************************************************
    // Pin synchroniser and clock source selection
    // ****************************************************************
    logic pinSync;
    logic pinEdge;
    logic srcPulse;
    logic prePulse;
    logic advance;

    ptc_sync u_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .asyncIn(ext_count_pin),
        .syncOut(pinSync)
    );

    // Falling edge when the polarity bit is one, rising edge otherwise
    assign pinEdge = edge_polarity_sel ? (st_ff.pinPrev && !pinSync)
                                       : (!st_ff.pinPrev && pinSync);
    assign srcPulse = count_run &&
                      (count_source_sel ? pinEdge : st_ff.instruction_tick);

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    // An access is taken only in the cycle where waitrequest is low,
    // so each register side effect happens exactly once per access.
    logic accept;
    logic wrLane0;
    logic countWrite;
    logic lowRead;

    assign accept = !st_ff.waitReq && (avs_read || avs_write);
    assign wrLane0 = accept && avs_write && avs_byteenable[0];
    assign countWrite = wrLane0 && (avs_address == ptc_pkg::OFF_COUNT_LOW);
    // The snapshot is taken while the low byte is latched for the answer
    assign lowRead = st_ff.waitReq && avs_read && (avs_address == ptc_pkg::OFF_COUNT_LOW);

    ptc_prescaler #(
        .WIDTH(ptc_pkg::PRESCALE_WIDTH)
    ) u_pre (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .clearCount(countWrite && !divider_bypass),
        .ratioSel(divider_ratio_sel),
        .srcPulse(srcPulse && !divider_bypass),
        .outPulse(prePulse)
    );

    // Counting is frozen while the write hold-off is still running
    assign advance = (divider_bypass ? srcPulse : prePulse)
                     && (st_ff.holdoff == 2'h0);

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        nxt_st = st_ff;

        // Instruction tick: one mclk pulse per TICK_DIV cycles
        nxt_st.instruction_tick = 1'b0;
        if (st_ff.tickDiv == ($clog2(TICK_DIV))'(TICK_DIV - 1)) begin
            nxt_st.tickDiv = '0;
            nxt_st.instruction_tick = 1'b1;
        end else begin
            nxt_st.tickDiv = st_ff.tickDiv + ($clog2(TICK_DIV))'(1);
        end

        nxt_st.pinPrev = pinSync;

        // Hold-off counts down on instruction ticks
        if (st_ff.holdoff != 2'h0 && st_ff.instruction_tick) begin
            nxt_st.holdoff = st_ff.holdoff - 2'h1;
        end

        // Counter advance and overflow detection
        if (advance) begin
            nxt_st.countLow = st_ff.countLow + 8'h01;
            if (narrow_width_sel) begin
                if (st_ff.countLow == ptc_pkg::BYTE_ONES) begin
                    nxt_st.overflow_flag = 1'b1;
                end
            end else if (st_ff.countLow == ptc_pkg::BYTE_ONES) begin
                nxt_st.countHigh = st_ff.countHigh + 8'h01;
                if (st_ff.countHigh == ptc_pkg::BYTE_ONES) begin
                    nxt_st.overflow_flag = 1'b1;
                end
            end
        end

        // Bus handshake: one wait cycle, then the access is taken
        nxt_st.waitReq = 1'b1;
        if (st_ff.waitReq && (avs_read || avs_write)) begin
            nxt_st.waitReq = 1'b0;
        end

        // Read data is prepared during the wait cycle and stands at accept
        if (st_ff.waitReq && avs_read) begin
            case (avs_address)
                ptc_pkg::OFF_CONTROL: begin
                    nxt_st.readData = {24'h000000, st_ff.timer_control};
                end
                ptc_pkg::OFF_COUNT_LOW: begin
                    nxt_st.readData = {24'h000000, st_ff.countLow};
                end
                ptc_pkg::OFF_COUNT_HIGH: begin
                    nxt_st.readData = {24'h000000, st_ff.count_high_buffer};
                end
                ptc_pkg::OFF_STATUS: begin
                    nxt_st.readData = {30'h00000000, st_ff.overflow_irq_en,
                                       st_ff.overflow_flag};
                end
                default: begin
                    nxt_st.readData = 32'h00000000;
                end
            endcase
        end

        // Reading the low byte snapshots the live high byte in the same cycle,
        // so a carry between the two cannot split the pair
        if (lowRead && !narrow_width_sel) begin
            nxt_st.count_high_buffer = st_ff.countHigh;
        end

        // Register writes
        if (wrLane0) begin
            case (avs_address)
                ptc_pkg::OFF_CONTROL: begin
                    nxt_st.timer_control = avs_writedata[7:0];
                end
                ptc_pkg::OFF_COUNT_LOW: begin
                    nxt_st.countLow = avs_writedata[7:0];
                    if (!narrow_width_sel) begin
                        nxt_st.countHigh = st_ff.count_high_buffer;
                    end
                    nxt_st.holdoff = ptc_pkg::WRITE_HOLDOFF_TICKS;
                end
                ptc_pkg::OFF_COUNT_HIGH: begin
                    nxt_st.count_high_buffer = avs_writedata[7:0];
                end
                ptc_pkg::OFF_STATUS: begin
                    nxt_st.overflow_irq_en = avs_writedata[ptc_pkg::BIT_OVF_EN];
                    // Write one to clear; a wrap in the same cycle wins
                    if (avs_writedata[ptc_pkg::BIT_OVF_FLAG] && !(advance &&
                        st_ff.countLow == ptc_pkg::BYTE_ONES &&
                        (narrow_width_sel || st_ff.countHigh == ptc_pkg::BYTE_ONES))) begin
                        nxt_st.overflow_flag = 1'b0;
                    end
                end
                default: begin
                    nxt_st.readData = st_ff.readData;
                end
            endcase
        end

        nxt_st.irq = nxt_st.overflow_flag && nxt_st.overflow_irq_en;
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_ff <= '0;
            st_ff.timer_control <= ptc_pkg::CONTROL_RESET;
            st_ff.waitReq <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign avs_readdata = st_ff.readData;
    assign avs_waitrequest = st_ff.waitReq;
    assign overflowIrq = st_ff.irq;

endmodule : ptc_timer

`default_nettype wire

//--- hw/ptc_pkg.sv
// Purpose: Shared constants for the prescaled timer/counter
// Assumes: 40 MHz mclk, instruction tick is mclk divided by four
// Notes:   Register offsets are byte addresses on a 32-bit Avalon-MM slave
`default_nettype none

package ptc_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [3:0] OFF_CONTROL = 4'h0;
    localparam logic [3:0] OFF_COUNT_LOW = 4'h4;
    localparam logic [3:0] OFF_COUNT_HIGH = 4'h8;
    localparam logic [3:0] OFF_STATUS = 4'hc;

    // ****************************************************************
    // Control register fields
    // ****************************************************************
    localparam int BIT_RUN = 7;
    localparam int BIT_NARROW = 6;
    localparam int BIT_SOURCE = 5;
    localparam int BIT_EDGE = 4;
    localparam int BIT_BYPASS = 3;
    localparam int RATIO_MSB = 2;
    localparam int RATIO_LSB = 0;
    localparam logic [7:0] CONTROL_RESET = 8'hff;

    // Status register fields
    localparam int BIT_OVF_FLAG = 0;
    localparam int BIT_OVF_EN = 1;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int MCLK_PER_TICK = 4;
    localparam logic [1:0] WRITE_HOLDOFF_TICKS = 2'h2;
    localparam int PRESCALE_WIDTH = 8;

    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_ONES = 8'hff;

endpackage : ptc_pkg

`default_nettype wire

//--- hw/ptc_sync.sv
// Purpose: Two-flop synchroniser for the external count pin
// Assumes: Input is asynchronous to mclk
// Notes:   Only the second stage may be read by other logic
`default_nettype none

module ptc_sync (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Data
    input wire logic asyncIn,
    output logic syncOut
);

    typedef struct packed {
        logic stage1;
        logic stage2;
    } ptc_sync_s;

    ptc_sync_s st_ff;
    ptc_sync_s nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.stage1 = asyncIn;
        nxt_st.stage2 = st_ff.stage1;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign syncOut = st_ff.stage2;

endmodule : ptc_sync

`default_nettype wire

//--- hw/ptc_prescaler.sv
// Purpose: Power-of-two prescaler, divide by 2 up to 256
// Assumes: srcPulse is a one-cycle pulse in the mclk domain
// Notes:   Output pulse is combinational from the stored count and srcPulse
`default_nettype none

module ptc_prescaler #(
    parameter int WIDTH = ptc_pkg::PRESCALE_WIDTH
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Control
    input wire logic clearCount,
    input wire logic [2:0] ratioSel,
    // Pulses
    input wire logic srcPulse,
    output logic outPulse
);

    typedef struct packed {
        logic [WIDTH-1:0] count;
    } ptc_pre_s;

    ptc_pre_s st_ff;
    ptc_pre_s nxt_st;
    logic [WIDTH-1:0] mask;

    // Ratio 2^(code+1): the pulse fires when the low code+1 bits are all ones
    always_comb begin
        // Widen the code first: in three bits, code 7 plus one would wrap to zero
        mask = WIDTH'((1 << (int'(ratioSel) + 1)) - 1);
        outPulse = srcPulse && ((st_ff.count & mask) == mask);
    end

    always_comb begin
        nxt_st = st_ff;
        if (clearCount) begin
            nxt_st.count = '0;
        end else if (srcPulse) begin
            nxt_st.count = st_ff.count + WIDTH'(1);
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

endmodule : ptc_prescaler

`default_nettype wire

//--- tb/ptc_timer_chk.sv
// Purpose: Port-level checks on the timer register slave
// Assumes: One request at a time, held until waitrequest is low
// Notes:   Shadows follow accepted writes to control and irq enable
`default_nettype none

module ptc_timer_chk #(
    parameter int TICK_DIV = 4
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Pin and interrupt
    input wire logic ext_count_pin,
    input wire logic overflowIrq
);
    // ****************
    // Shadows
    // ****************
    logic [7:0] ctrlShadow_ff;
    logic enShadow_ff;
    logic wrAcc;
    logic rdAcc;
    assign wrAcc = avs_write && !avs_waitrequest && avs_byteenable[0];
    assign rdAcc = avs_read && !avs_waitrequest;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ctrlShadow_ff <= ptc_pkg::CONTROL_RESET;
            enShadow_ff <= 1'b0;
        end else if (wrAcc && avs_address == ptc_pkg::OFF_CONTROL) begin
            ctrlShadow_ff <= avs_writedata[7:0];
        end else if (wrAcc && avs_address == ptc_pkg::OFF_STATUS) begin
            enShadow_ff <= avs_writedata[ptc_pkg::BIT_OVF_EN];
        end
    end

    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    sequence reqWaiting;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence answered;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    answer_next_a: assert property (reqWaiting |=> answered)
        else $error("request not answered for exactly one cycle");
    wait_needs_req_a: assert property (!avs_waitrequest |-> (avs_read || avs_write))
        else $error("answer without a request");
    upper_zero_a: assert property (rdAcc |-> avs_readdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    unmapped_zero_a: assert property (rdAcc && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    ctrl_readback_a: assert property (rdAcc && avs_address == ptc_pkg::OFF_CONTROL
        |-> avs_readdata[7:0] == ctrlShadow_ff)
        else $error("control readback differs");
    irq_mask_a: assert property (overflowIrq |-> enShadow_ff || $past(enShadow_ff))
        else $error("interrupt while masked");
    reset_idle_a: assert property ($fell(sys_rst)
        |-> avs_waitrequest && !overflowIrq && avs_readdata == 32'h0)
        else $error("outputs not idle after reset");
    data_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data changed without a read");
endmodule : ptc_timer_chk

bind ptc_timer ptc_timer_chk #(.TICK_DIV(TICK_DIV)) chk (
    .mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ext_count_pin(ext_count_pin), .overflowIrq(overflowIrq)
);

`default_nettype wire

//--- tb/ptc_timer_tb.sv
// Purpose: Register-level test of the prescaled timer/counter
// Assumes: Slave answers each access after one cycle
// Notes:   Span counts are compared as differences between two low-byte reads
`default_nettype none

module ptc_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TK = ptc_pkg::MCLK_PER_TICK;
    localparam logic [3:0] CTL = ptc_pkg::OFF_CONTROL;
    localparam logic [3:0] LOW = ptc_pkg::OFF_COUNT_LOW;
    localparam logic [3:0] HIGH = ptc_pkg::OFF_COUNT_HIGH;
    localparam logic [3:0] STS = ptc_pkg::OFF_STATUS;
    logic mclk;
    logic sys_rst;
    logic [3:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic ext_count_pin;
    logic overflowIrq;
    int mismatches;
    int compares;
    logic [7:0] v;

    ptc_timer #(.TICK_DIV(TK)) uut (
        .mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .ext_count_pin(ext_count_pin), .overflowIrq(overflowIrq)
    );

    // ****************
    // Tasks
    // ****************
    task automatic report_and_stop();
        $display("mismatches=%0d compares=%0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chkIn(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
        compares++;
        if (!(got >= lo && got <= hi) || $isunknown(got)) begin
            mismatches++;
            $display("mismatch at %0t: got %h outside %h to %h", $time, got, lo, hi);
        end
    endtask : chkIn

    // Request is held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
            output logic [7:0] rd);
        @(posedge mclk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h000000, d};
        do begin
            @(posedge mclk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] x;
        bus(1'b1, a, d, x);
    endtask : wr

    task automatic rdChk(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] x;
        bus(1'b0, a, 8'h00, x);
        chk(x, e);
    endtask : rdChk

    // Two low-byte reads c cycles plus six per pin toggle apart, so tick phase cannot matter
    task automatic span(input int c, input int pins, input logic [7:0] e);
        logic [7:0] a;
        logic [7:0] b;
        bus(1'b0, LOW, 8'h00, a);
        for (int i = 0; i < pins; i++) begin
            ext_count_pin <= ~ext_count_pin;
            repeat (6) @(posedge mclk);
        end
        repeat (c - 3) @(posedge mclk);
        bus(1'b0, LOW, 8'h00, b);
        chk(b - a, e);
    endtask : span

    // ****************
    // Sequence
    // ****************
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        report_and_stop();
    end

    initial begin
        sys_rst = 1'b1;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        ext_count_pin = 1'b0;
        mismatches = 0;
        compares = 0;
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        rdChk(CTL, 8'hff);
        rdChk(4'h5, 8'h00);
        wr(CTL, 8'h5a);
        rdChk(CTL, 8'h5a);
        avs_byteenable <= 4'h0;
        wr(CTL, 8'ha5);
        avs_byteenable <= 4'hf;
        rdChk(CTL, 8'h5a);
        // Stopped 16-bit counter: buffered high byte
        wr(CTL, 8'h08);
        wr(HIGH, 8'h12);
        wr(LOW, 8'h34);
        wr(HIGH, 8'hab);
        repeat (40) @(posedge mclk);
        rdChk(LOW, 8'h34);
        rdChk(HIGH, 8'h12);
        wr(CTL, 8'hc8);
        span(TK * 10, 0, 8'h0a);
        wr(LOW, 8'h40);
        repeat (38) @(posedge mclk);
        bus(1'b0, LOW, 8'h00, v);
        chkIn(v, 8'h47, 8'h48);
        for (int c = 0; c < 8; c++) begin
            wr(CTL, 8'hc0 | 8'(c));
            span((TK * 4) << c, 0, 8'h02);
        end
        wr(CTL, 8'he8);
        span(9, 5, 8'h03);
        wr(CTL, 8'hf8);
        span(9, 3, 8'h02);
        // Prescaler left part-way while stopped, then cleared by a count write
        wr(CTL, 8'h42);
        wr(LOW, 8'h00);
        wr(CTL, 8'hc2);
        repeat (20) @(posedge mclk);
        wr(CTL, 8'h42);
        wr(LOW, 8'h00);
        repeat (20) @(posedge mclk);
        wr(CTL, 8'hc2);
        repeat (24) @(posedge mclk);
        bus(1'b0, LOW, 8'h00, v);
        chk(v, 8'h00);
        // Running 16-bit counter carries into the high byte
        wr(CTL, 8'h08);
        wr(HIGH, 8'h7f);
        wr(LOW, 8'hff);
        wr(CTL, 8'h88);
        repeat (20) @(posedge mclk);
        bus(1'b0, LOW, 8'h00, v);
        chk(v, 8'h03);
        rdChk(HIGH, 8'h80);
        // Overflow flag, mask and clear
        wr(CTL, 8'hc8);
        wr(STS, 8'h03);
        wr(LOW, 8'hfe);
        for (int n = 0; n < 100 && overflowIrq !== 1'b1; n++) @(posedge mclk);
        chk({7'h00, overflowIrq}, 8'h01);
        wr(CTL, 8'h48);
        rdChk(STS, 8'h03);
        wr(STS, 8'h00);
        rdChk(STS, 8'h01);
        chk({7'h00, overflowIrq}, 8'h00);
        wr(STS, 8'h03);
        rdChk(STS, 8'h02);
        chk({7'h00, overflowIrq}, 8'h00);
        report_and_stop();
    end
endmodule : ptc_timer_tb

`default_nettype wire
